//--- wdat_checker.sv
`timescale 1ns/1ps
module wdat_checker
  import wdat_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic          core_clk,        // clock
  input wire logic          arst_n,          // reset
  input wire logic          wdOverflow,      // overflow
  input wire logic          fetchValid,      // fetch strobe
  input wire logic [AW-1:0] fetchAddr,       // fetch address
  input wire logic          lowSpeedModeOne, // slow mode
  input wire logic          sysResetReq,     // reset request
  input wire logic          hfOscRestart,    // osc restart
  input wire logic          trapInterrupt,   // trap pulse
  input wire logic          wdInterrupt      // wd pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Reset length counter; any new cause restarts it
  logic [7:0] rstCnt_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) rstCnt_q <= 8'h0;
    else rstCnt_q <= (sysResetReq && !fetchValid && !wdOverflow) ? rstCnt_q + 8'h1 : 8'h0;
  end
  a_reset_bound: assert property (rstCnt_q <= RST_CYCLES)
    else $error("reset request too long");
  a_osc_low_speed: assert property ($rose(sysResetReq) && $past(lowSpeedModeOne) |-> hfOscRestart)
    else $error("no osc restart");
  a_osc_with_reset: assert property (hfOscRestart |-> sysResetReq)
    else $error("osc restart without reset");
  a_sfr_fetch_trap: assert property (fetchValid && fetchAddr <= 'h3f |=> trapInterrupt || sysResetReq)
    else $error("special area fetch missed");
  a_dbuf_fetch_trap: assert property (fetchValid && fetchAddr inside {['h0f80:'h0fff]}
    |=> trapInterrupt || sysResetReq)
    else $error("buffer area fetch missed");
  a_rom_no_trap: assert property (fetchValid && fetchAddr inside {['h0240:'h0f7f]} |=> !trapInterrupt)
    else $error("trap outside areas");
  a_idle_no_trap: assert property (!fetchValid |=> !trapInterrupt)
    else $error("trap without fetch");
  a_trap_one_kind: assert property (trapInterrupt |-> !$rose(sysResetReq) || $past(wdOverflow))
    else $error("trap gave both answers");
  a_wd_answer: assert property (wdOverflow |=> wdInterrupt || sysResetReq)
    else $error("overflow unanswered");
  c_trap_irq: cover property (trapInterrupt);
  c_slow_reset: cover property ($rose(sysResetReq) && hfOscRestart);
  c_wd_irq: cover property (wdInterrupt);
endmodule

bind wdat_top wdat_checker #(.AW(AW)) u_chk (.core_clk, .arst_n, .wdOverflow, .fetchValid,
  .fetchAddr, .lowSpeedModeOne, .sysResetReq, .hfOscRestart, .trapInterrupt, .wdInterrupt);

//--- wdat_fetch_if.sv
`timescale 1ns/1ps
interface wdat_fetch_if #(
  parameter int AW = 16
);
  logic          fetchValid;
  logic [AW-1:0] fetchAddr;
  logic          ramTrapEnable;
  logic          trapHit;

  modport detector (input fetchValid, input fetchAddr, input ramTrapEnable, output trapHit);
  modport owner    (output fetchValid, output fetchAddr, output ramTrapEnable, input trapHit);
endinterface

//--- wdat_fetch_model.sv
`timescale 1ns/1ps
module wdat_fetch_model (
  input  wire logic        core_clk,   // clock
  input  wire logic        arst_n,     // reset
  input  wire logic        go,         // fetch wanted
  input  wire logic [15:0] addr,       // wanted address
  output logic             fetchValid, // fetch strobe
  output logic      [15:0] fetchAddr   // fetch address
);
  // ==========================================================
  // Core fetch stage; go and addr are registered into the fetch strobe and address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetchValid <= 1'b0;
      fetchAddr  <= 16'h0;
    end else begin
      fetchValid <= go;
      // Idle address toggles so no one leans on a stale value
      fetchAddr  <= go ? addr : ~fetchAddr;
    end
  end
endmodule

//--- wdat_pkg.sv
package wdat_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] WDAT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] WDAT_CODE_OFS   = 8'h04;
  localparam logic [7:0] WDAT_STAT_OFS   = 8'h08;
  localparam logic [7:0] WDAT_MASK_OFS   = 8'h0c;
  localparam logic [7:0] WDAT_ACTIVE_OFS = 8'h10;

  // ==========================================================
  // Control register fields and reset value
  localparam int         WDAT_OVF_SEL_BIT  = 0;
  localparam int         WDAT_PERIOD_LSB   = 1;
  localparam int         WDAT_WD_EN_BIT    = 3;
  localparam int         WDAT_TRAP_ACT_BIT = 4;
  localparam int         WDAT_RAM_TRAP_BIT = 5;
  localparam logic [7:0] WDAT_CTRL_RST     = 8'h39;
  localparam logic [7:0] WDAT_CODE_COMMIT  = 8'hd2;

  // ==========================================================
  // Status and mask bits
  localparam int         WDAT_ST_WD_RST   = 0;
  localparam int         WDAT_ST_WD_IRQ   = 1;
  localparam int         WDAT_ST_TRAP_IRQ = 2;
  localparam int         WDAT_ST_TRAP_RST = 3;
  localparam int         WDAT_ST_W        = 4;
  localparam logic [3:0] WDAT_MASK_RST    = 4'h0;

  // ==========================================================
  // Reset duration: 24 periods of fc, fc taken as 16 MHz
  localparam int FC_KHZ          = 16000;
  localparam int CORE_CLK_KHZ    = 125000;
  localparam int RST_FC_PERIODS  = 24;
  localparam int RST_TIME_PS     = RST_FC_PERIODS * (1000000000 / FC_KHZ);
  localparam int RST_CYCLES      = (RST_TIME_PS / 1000) * CORE_CLK_KHZ / 1000000;
  localparam int RST_CNT_W       = 8;

endpackage

//--- wdat_reset_pulse.sv
`timescale 1ns/1ps
module wdat_reset_pulse
  import wdat_pkg::*;
(
  input  wire logic core_clk,     // System clock
  input  wire logic arst_n,       // Async reset, active low
  input  wire logic trigger,      // One-cycle reset request cause
  input  wire logic lowSpeed,     // Low-speed mode one active
  output logic      resetReq,     // Held internal reset request
  output logic      oscRestart    // Fast oscillator restart
);
  logic [RST_CNT_W-1:0] cnt_q;
  logic [RST_CNT_W-1:0] cnt_d;
  logic                 osc_q;

  // Retriggers restart the count, so a retriggered request lasts longer than the bound
  assign cnt_d = trigger ? RST_CNT_W'(RST_CYCLES) :
                 (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= '0;
      resetReq <= 1'b0;
      osc_q    <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      resetReq <= (cnt_d != '0);
      osc_q    <= trigger ? lowSpeed : (cnt_d != '0) && osc_q;
    end
  end

  assign oscRestart = osc_q;
endmodule

//--- wdat_tb_top.sv
`timescale 1ns/1ps
module wdat_tb_top;
  import wdat_pkg::*;
  logic        core_clk, arst_n, hsel, hwrite, wdOverflow, go, lowSpeedModeOne, fetchValid;
  logic        sysResetReq, hfOscRestart, trapInterrupt, wdInterrupt, irq, hreadyout, hresp;
  logic        prevRst;
  logic [1:0]  htrans;
  logic [15:0] addr, fetchAddr;
  logic [31:0] haddr, hwdata, hrdata, rdv, seed;
  logic [2:0]  expQ[$];
  int          errors, check_count, rl;
  wdat_top #(.AW(16)) dut (.core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .wdOverflow, .fetchValid,
    .fetchAddr, .lowSpeedModeOne, .sysResetReq, .hfOscRestart, .trapInterrupt, .wdInterrupt, .irq);
  wdat_fetch_model fm (.core_clk, .arst_n, .go, .addr, .fetchValid, .fetchAddr);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic hit(logic [15:0] a, logic ram);
    return a <= 16'h3f || a inside {[16'hf80:16'hfff]} || (ram && a inside {[16'h40:16'h23f]});
  endfunction
  function automatic logic [31:0] pop();
    return expQ.size() > 0 ? 32'(expQ.pop_front()) : 32'h7;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic waitrdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    hwrite <= w;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    waitrdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    waitrdy();
    rdv = hrdata;
  endtask
  task automatic fetch(logic [15:0] a, logic [2:0] k);
    @(posedge core_clk);
    go   <= 1'b1;
    addr <= a;
    if (k != 0) expQ.push_back(k);
    @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic ovf(logic [2:0] k);
    @(posedge core_clk);
    wdOverflow <= 1'b1;
    expQ.push_back(k);
    @(posedge core_clk);
    wdOverflow <= 1'b0;
    repeat (195) @(posedge core_clk);
  endtask
  // ==========================================================
  // Event monitor
  always @(negedge core_clk) begin
    if (arst_n) begin
      if (trapInterrupt) chk("trap", pop(), 32'h1);
      if (wdInterrupt) chk("wdirq", pop(), 32'h2);
      if (sysResetReq && !prevRst) chk("reset", pop(), hfOscRestart ? 32'h4 : 32'h3);
      if (sysResetReq) rl++;
      else if (prevRst) chk("length", 32'(RST_CYCLES), 32'(rl));
      if (!sysResetReq) rl = 0;
      prevRst = sysResetReq;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {arst_n, hsel, hwrite, wdOverflow, go, lowSpeedModeOne, prevRst} = '0;
    {htrans, addr, haddr, hwdata} = '0;
    seed = 32'h4de2;
    errors = 0;
    check_count = 0;
    rl = 0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(0, WDAT_CTRL_OFS, 0);
    chk("ctrl", 0, rdv);
    chk("hresp", 0, hresp);
    bus(0, WDAT_ACTIVE_OFS, 0);
    chk("active", 32'h39, rdv);
    bus(0, 8'h20, 0);
    chk("unmapped", 0, rdv);
    lowSpeedModeOne <= 1'b1;
    fetch(16'h0f80, 4);
    repeat (195) @(posedge core_clk);
    lowSpeedModeOne <= 1'b0;
    ovf(3);
    bus(1, WDAT_CTRL_OFS, 32'h29);
    fetch(16'h0010, 1);
    chk("irq off", 0, irq);
    bus(1, WDAT_MASK_OFS, 32'h4);
    bus(0, WDAT_STAT_OFS, 0);
    // Earlier overflow reset and trap reset left bits 0 and 3 set
    chk("status", 32'hd, rdv);
    chk("irq on", 1, irq);
    bus(1, WDAT_STAT_OFS, 32'h4);
    bus(0, WDAT_STAT_OFS, 0);
    chk("cleared", 32'h9, rdv);
    chk("irq clr", 0, irq);
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      seed = xs(seed);
      go   <= 1'b1;
      addr <= {4'h0, seed[11:0]};
      if (hit({4'h0, seed[11:0]}, 1'b1)) expQ.push_back(3'h1);
    end
    @(posedge core_clk);
    go <= 1'b0;
    bus(1, WDAT_CTRL_OFS, 32'h09);
    fetch(16'h0100, 1);
    bus(1, WDAT_CODE_OFS, 32'h4e);
    fetch(16'h0100, 1);
    bus(1, WDAT_CODE_OFS, 32'hd2);
    fetch(16'h0100, 0);
    fetch(16'h0020, 1);
    bus(1, WDAT_CTRL_OFS, 32'h29);
    fetch(16'h0100, 0);
    bus(1, WDAT_CODE_OFS, 32'hd2);
    fetch(16'h0100, 1);
    bus(1, WDAT_CTRL_OFS, 32'h28);
    bus(1, WDAT_CTRL_OFS, 32'h29);
    bus(0, WDAT_ACTIVE_OFS, 0);
    chk("active", 32'h28, rdv);
    ovf(2);
    chk("pending", 0, 32'(expQ.size()));
    // Mid-run reset brings the control register back to its reset value
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(0, WDAT_ACTIVE_OFS, 0);
    chk("reset active", 32'h39, rdv);
    chk("reset req", 0, sysResetReq);
    finish_test();
  end
endmodule

//--- wdat_top.sv
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module wdat_top
  import wdat_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic          core_clk,        // System clock, 125 MHz
  input  wire logic          arst_n,          // Async reset, active low
  input  wire logic          hsel,            // AHB slave select
  input  wire logic [31:0]   haddr,           // AHB address
  input  wire logic [1:0]    htrans,          // AHB transfer type
  input  wire logic          hwrite,          // AHB write
  input  wire logic [2:0]    hsize,           // AHB size
  input  wire logic [31:0]   hwdata,          // AHB write data
  input  wire logic          hready,          // AHB ready in
  output logic      [31:0]   hrdata,          // AHB read data
  output logic               hreadyout,       // AHB ready out
  output logic               hresp,           // AHB response, always OKAY
  input  wire logic          wdOverflow,      // Watchdog counter overflow pulse
  input  wire logic          fetchValid,      // Instruction fetch strobe
  input  wire logic [AW-1:0] fetchAddr,       // Instruction fetch address
  input  wire logic          lowSpeedModeOne, // Low-speed mode one active
  output logic               sysResetReq,     // Internal hardware reset request
  output logic               hfOscRestart,    // Restart fast oscillator
  output logic               trapInterrupt,   // Non-maskable trap request pulse
  output logic               wdInterrupt,     // Watchdog interrupt pulse
  output logic               irq              // Level status interrupt
);
  import wdat_pkg::*;

  // ==========================================================
  // Bus slave: address phase capture
  logic       wrPend_q;
  logic       wrPend_d;
  logic [7:0] wrAddr_q;
  logic [7:0] wrAddr_d;

  wire addrPhase = hsel && htrans[1] && hready;
  wire rdAccept  = addrPhase && !hwrite;
  wire wrAccept  = addrPhase && hwrite;

  assign wrPend_d = wrAccept;
  assign wrAddr_d = wrAccept ? haddr[7:0] : wrAddr_q;

  // Write strobes in the data phase
  wire wrCtrl = wrPend_q && (wrAddr_q == WDAT_CTRL_OFS);
  wire wrCode = wrPend_q && (wrAddr_q == WDAT_CODE_OFS);
  wire wrStat = wrPend_q && (wrAddr_q == WDAT_STAT_OFS);
  wire wrMask = wrPend_q && (wrAddr_q == WDAT_MASK_OFS);

  // ==========================================================
  // Control register
  logic       ovfSel_q;
  logic       ovfSel_d;
  logic [1:0] period_q;
  logic [1:0] period_d;
  logic       wdEn_q;
  logic       wdEn_d;
  logic       trapAct_q;
  logic       trapAct_d;
  logic       ramPend_q;
  logic       ramPend_d;
  logic       ramTrap_q;
  logic       ramTrap_d;

  // Once cleared the overflow select can be set again only by reset
  assign ovfSel_d  = wrCtrl ? (ovfSel_q && hwdata[WDAT_OVF_SEL_BIT]) : ovfSel_q;
  assign period_d  = wrCtrl ? hwdata[WDAT_PERIOD_LSB +: 2] : period_q;
  assign wdEn_d    = wrCtrl ? hwdata[WDAT_WD_EN_BIT] : wdEn_q;
  assign trapAct_d = wrCtrl ? hwdata[WDAT_TRAP_ACT_BIT] : trapAct_q;
  assign ramPend_d = wrCtrl ? hwdata[WDAT_RAM_TRAP_BIT] : ramPend_q;

  // The new RAM trap choice stays shadowed until the commit code
  wire codeCommit = wrCode && (hwdata[7:0] == WDAT_CODE_COMMIT);
  assign ramTrap_d = codeCommit ? ramPend_q : ramTrap_q;

  // ==========================================================
  // Trap detection
  wdat_fetch_if #(.AW(AW)) fetchBus ();

  assign fetchBus.fetchValid    = fetchValid;
  assign fetchBus.fetchAddr     = fetchAddr;
  assign fetchBus.ramTrapEnable = ramTrap_q;

  wdat_trap_detect #(
    .AW (AW)
  ) u_detect (
    .fetch (fetchBus)
  );

  wire trapHit   = fetchBus.trapHit;
  wire trapToIrq = trapHit && !trapAct_q;
  wire trapToRst = trapHit && trapAct_q;
  wire wdToRst   = wdOverflow && ovfSel_q;
  wire wdToIrq   = wdOverflow && !ovfSel_q;

  // ==========================================================
  // Reset request generator
  wire rstTrigger = wdToRst || trapToRst;

  wdat_reset_pulse u_rst (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .trigger    (rstTrigger),
    .lowSpeed   (lowSpeedModeOne),
    .resetReq   (sysResetReq),
    .oscRestart (hfOscRestart)
  );

  // ==========================================================
  // Status, mask and interrupt
  logic [WDAT_ST_W-1:0] status_q;
  logic [WDAT_ST_W-1:0] status_d;
  logic [WDAT_ST_W-1:0] mask_q;
  logic [WDAT_ST_W-1:0] mask_d;
  logic [WDAT_ST_W-1:0] events;
  logic [WDAT_ST_W-1:0] clrBits;

  assign events[WDAT_ST_WD_RST]   = wdToRst;
  assign events[WDAT_ST_WD_IRQ]   = wdToIrq;
  assign events[WDAT_ST_TRAP_IRQ] = trapToIrq;
  assign events[WDAT_ST_TRAP_RST] = trapToRst;

  assign clrBits  = wrStat ? hwdata[WDAT_ST_W-1:0] : '0;
  // A new event in the clearing cycle survives the clear
  assign status_d = (status_q & ~clrBits) | events;
  assign mask_d   = wrMask ? hwdata[WDAT_ST_W-1:0] : mask_q;

  wire irq_d = |(status_d & mask_d);

  // ==========================================================
  // Read data, built from next-state values so a read right
  // after a write sees the written value
  logic [31:0] rdMux;

  wire rdStat   = haddr[7:0] == WDAT_STAT_OFS;
  wire rdMask   = haddr[7:0] == WDAT_MASK_OFS;
  wire rdActive = haddr[7:0] == WDAT_ACTIVE_OFS;

  // Control and code registers are write-only and read as zero
  assign rdMux = rdStat   ? {{(32-WDAT_ST_W){1'b0}}, status_d} :
                 rdMask   ? {{(32-WDAT_ST_W){1'b0}}, mask_d} :
                 rdActive ? {26'h0, ramTrap_d, trapAct_d, wdEn_d, period_d, ovfSel_d} :
                 32'h0000_0000;

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_q  <= wrPend_d;
      wrAddr_q  <= wrAddr_d;
      hrdata    <= rdAccept ? rdMux : hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovfSel_q  <= WDAT_CTRL_RST[WDAT_OVF_SEL_BIT];
      period_q  <= WDAT_CTRL_RST[WDAT_PERIOD_LSB +: 2];
      wdEn_q    <= WDAT_CTRL_RST[WDAT_WD_EN_BIT];
      trapAct_q <= WDAT_CTRL_RST[WDAT_TRAP_ACT_BIT];
      ramPend_q <= WDAT_CTRL_RST[WDAT_RAM_TRAP_BIT];
      ramTrap_q <= WDAT_CTRL_RST[WDAT_RAM_TRAP_BIT];
    end else begin
      ovfSel_q  <= ovfSel_d;
      period_q  <= period_d;
      wdEn_q    <= wdEn_d;
      trapAct_q <= trapAct_d;
      ramPend_q <= ramPend_d;
      ramTrap_q <= ramTrap_d;
    end
  end

  // Trap requests bypass the master flag; each hit pulses again so
  // a trap during a service routine preempts it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q      <= '0;
      mask_q        <= WDAT_MASK_RST;
      irq           <= 1'b0;
      trapInterrupt <= 1'b0;
      wdInterrupt   <= 1'b0;
    end else begin
      status_q      <= status_d;
      mask_q        <= mask_d;
      irq           <= irq_d;
      trapInterrupt <= trapToIrq;
      wdInterrupt   <= wdToIrq;
    end
  end

endmodule

//--- wdat_trap_detect.sv
`timescale 1ns/1ps
module wdat_trap_detect #(
  parameter int          AW       = 16,
  parameter logic [15:0] RAM_LO   = 16'h0040,
  parameter logic [15:0] RAM_HI   = 16'h023f,
  parameter logic [15:0] SFR_LO   = 16'h0000,
  parameter logic [15:0] SFR_HI   = 16'h003f,
  parameter logic [15:0] DBUF_LO  = 16'h0f80,
  parameter logic [15:0] DBUF_HI  = 16'h0fff
) (
  wdat_fetch_if.detector fetch // Fetch address in, hit out
);
  wire inRam  = (fetch.fetchAddr >= RAM_LO[AW-1:0]) && (fetch.fetchAddr <= RAM_HI[AW-1:0]);
  wire inSfr  = (fetch.fetchAddr >= SFR_LO[AW-1:0]) && (fetch.fetchAddr <= SFR_HI[AW-1:0]);
  wire inDbuf = (fetch.fetchAddr >= DBUF_LO[AW-1:0]) && (fetch.fetchAddr <= DBUF_HI[AW-1:0]);

  // Data accesses never reach this port, so they can never trap
  assign fetch.trapHit = fetch.fetchValid &&
                         ((inRam && fetch.ramTrapEnable) ||
                          inSfr || inDbuf);
endmodule
